// ===== pscr_regs.sv
`timescale 1ns/100ps
module pscr_regs (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pscr_pkg::PSCR_ADDR_W-1:0] paddr,
  input wire logic [pscr_pkg::PSCR_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pscr_pkg::PSCR_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Raw synthesizer configuration
  output logic primary_ref_doubler_en,
  output logic [pscr_pkg::PSCR_CP_W-1:0] pump_current_code,
  output logic [pscr_pkg::PSCR_INT_DIV_W-1:0] feedback_int_divider,
  output logic [pscr_pkg::PSCR_FRAC_W-1:0] frac_numerator,
  output logic [pscr_pkg::PSCR_FRAC_W-1:0] frac_denominator,
  output pscr_pkg::pscr_order_t modulator_order,
  output pscr_pkg::pscr_dither_t modulator_dither_sel,
  output logic [pscr_pkg::PSCR_R2_W-1:0] loop_filter_r2_code,
  // Decoded synthesizer controls
  output logic [pscr_pkg::PSCR_CUR_W-1:0] pump_current_ua,
  output logic [pscr_pkg::PSCR_INT_DIV_W-1:0] fb_int_ratio,
  output logic [pscr_pkg::PSCR_FRAC_W-1:0] fb_frac_num,
  output logic [pscr_pkg::PSCR_FRAC_W-1:0] fb_frac_den,
  output logic fb_frac_active,
  output logic dither_active,
  // Pulse after any register write lands
  output logic config_update
);
  import pscr_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [PSCR_ADDR_W-3:0] word_idx;
  logic aligned;
  logic in_bank;
  logic is_status;
  logic mapped;
  logic [3:0] slot;
  logic setup_phase;
  logic access_phase;
  logic wr_fire;

  assign word_idx = paddr[PSCR_ADDR_W-1:2];
  assign aligned = (paddr[1:0] == PSCR_WORD_ALIGN);
  assign in_bank = aligned && (word_idx >= (PSCR_ADDR_W-2)'(PSCR_IDX_DOUBLER_AND_PUMP))
                   && (word_idx <= (PSCR_ADDR_W-2)'(PSCR_IDX_LOOP_FILTER_R2));
  assign is_status = aligned && (word_idx == (PSCR_ADDR_W-2)'(PSCR_IDX_SYNTH_STATUS));
  assign mapped = in_bank || is_status;
  assign slot = 4'(word_idx - (PSCR_ADDR_W-2)'(PSCR_IDX_DOUBLER_AND_PUMP));
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;

  // Zero wait states: the read word is staged during the setup cycle
  assign pready = 1'b1;
  // A write lands only at the completing access edge, only in lane 0, only if in the register bank (not status)
  assign wr_fire = access_phase && pwrite && in_bank && pstrb[0];

  // ----------------------------------------------------------------
  // Register storage, one generate slot per register
  // ----------------------------------------------------------------
  logic [PSCR_REG_W-1:0] regs_r [PSCR_NUM_REGS];
  logic [PSCR_REG_W-1:0] regs_nxt [PSCR_NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < PSCR_NUM_REGS; g++) begin : g_reg
      // Unwritable bits are forced low so reserved fields read as zero
      always_comb begin
        regs_nxt[g] = regs_r[g];
        if (wr_fire && (slot == 4'(g))) begin
          regs_nxt[g] = pwdata[PSCR_REG_W-1:0] & PSCR_MASK[g];
        end
      end

      // Reset values per slot: doubler on, pump 0x8, divider 0x066, dither off, R2 0x24
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_r[g] <= PSCR_RST[g];
        end else begin
          regs_r[g] <= regs_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign primary_ref_doubler_en = regs_r[PSCR_SLOT_DBL_PUMP][PSCR_DBL_BIT];
  assign pump_current_code = regs_r[PSCR_SLOT_DBL_PUMP][PSCR_CP_W-1:0];
  // Divider is split across two bytes; software should write high then low
  assign feedback_int_divider = {regs_r[PSCR_SLOT_DIV_HIGH][PSCR_INT_HI_W-1:0],
                                 regs_r[PSCR_SLOT_DIV_LOW]};
  assign frac_numerator = {regs_r[PSCR_SLOT_NUM_TOP][PSCR_FRAC_TOP_W-1:0],
                           regs_r[PSCR_SLOT_NUM_MID], regs_r[PSCR_SLOT_NUM_LOW]};
  assign frac_denominator = {regs_r[PSCR_SLOT_DEN_TOP][PSCR_FRAC_TOP_W-1:0],
                             regs_r[PSCR_SLOT_DEN_MID], regs_r[PSCR_SLOT_DEN_LOW]};
  assign modulator_order = pscr_order_t'(regs_r[PSCR_SLOT_MOD_CTRL][PSCR_ORDER_LSB+:2]);
  assign modulator_dither_sel = pscr_dither_t'(regs_r[PSCR_SLOT_MOD_CTRL][PSCR_DITHER_LSB+:2]);
  assign loop_filter_r2_code = regs_r[PSCR_SLOT_LF_R2][PSCR_R2_W-1:0];

  // ----------------------------------------------------------------
  // Decoded controls for the analog loop
  // ----------------------------------------------------------------
  logic den_zero;

  pscr_synth_decode u_decode (
    .pclk(pclk),
    .presetn(presetn),
    .pump_current_code(pump_current_code),
    .feedback_int_divider(feedback_int_divider),
    .frac_numerator(frac_numerator),
    .frac_denominator(frac_denominator),
    .modulator_order(modulator_order),
    .modulator_dither_sel(modulator_dither_sel),
    .pump_current_ua(pump_current_ua),
    .fb_int_ratio(fb_int_ratio),
    .fb_frac_num(fb_frac_num),
    .fb_frac_den(fb_frac_den),
    .fb_frac_active(fb_frac_active),
    .fb_den_zero(den_zero),
    .dither_active(dither_active)
  );

  // ----------------------------------------------------------------
  // Status word built from decoded state
  // ----------------------------------------------------------------
  logic [PSCR_DATA_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[PSCR_ST_RATIO_LSB+:PSCR_INT_DIV_W] = fb_int_ratio;
    status_word[PSCR_ST_FRAC_BIT] = fb_frac_active;
    status_word[PSCR_ST_DEN_ZERO_BIT] = den_zero;
    status_word[PSCR_ST_DITHER_BIT] = dither_active;
  end

  // ----------------------------------------------------------------
  // Read data, error and update strobe
  // ----------------------------------------------------------------
  logic [PSCR_DATA_W-1:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic update_r, update_nxt;

  // Staging at setup keeps prdata off the address path at the cost of one setup-cycle sample
  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup_phase) begin
      pslverr_nxt = !mapped;
      prdata_nxt = '0;
      if (!pwrite && in_bank) begin
        prdata_nxt = {{(PSCR_DATA_W-PSCR_REG_W){1'b0}}, regs_r[slot]};
      end else if (!pwrite && is_status) begin
        prdata_nxt = status_word;
      end
    end
    update_nxt = wr_fire;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
      update_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      update_r <= update_nxt;
    end
  end

  assign prdata = prdata_r;
  // Error only shown in the access phase so idle bus sees it low
  assign pslverr = pslverr_r && access_phase;
  assign config_update = update_r;

endmodule : pscr_regs

// ===== pscr_pkg.sv
package pscr_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int PSCR_ADDR_W = 12;
  localparam int PSCR_DATA_W = 32;
  localparam int PSCR_REG_W = 8;
  localparam int PSCR_NUM_REGS = 11;
  localparam logic [1:0] PSCR_WORD_ALIGN = 2'h0;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] PSCR_IDX_DOUBLER_AND_PUMP = 8'h39;
  localparam logic [7:0] PSCR_IDX_INT_DIV_HIGH = 8'h3A;
  localparam logic [7:0] PSCR_IDX_INT_DIV_LOW = 8'h3B;
  localparam logic [7:0] PSCR_IDX_FRAC_NUM_TOP = 8'h3C;
  localparam logic [7:0] PSCR_IDX_FRAC_NUM_MID = 8'h3D;
  localparam logic [7:0] PSCR_IDX_FRAC_NUM_LOW = 8'h3E;
  localparam logic [7:0] PSCR_IDX_FRAC_DEN_TOP = 8'h3F;
  localparam logic [7:0] PSCR_IDX_FRAC_DEN_MID = 8'h40;
  localparam logic [7:0] PSCR_IDX_FRAC_DEN_LOW = 8'h41;
  localparam logic [7:0] PSCR_IDX_MODULATOR_CTRL = 8'h42;
  localparam logic [7:0] PSCR_IDX_LOOP_FILTER_R2 = 8'h43;
  localparam logic [7:0] PSCR_IDX_SYNTH_STATUS = 8'h44;

  // Slots in the storage array, in index order
  localparam int PSCR_SLOT_DBL_PUMP = 0;
  localparam int PSCR_SLOT_DIV_HIGH = 1;
  localparam int PSCR_SLOT_DIV_LOW = 2;
  localparam int PSCR_SLOT_NUM_TOP = 3;
  localparam int PSCR_SLOT_NUM_MID = 4;
  localparam int PSCR_SLOT_NUM_LOW = 5;
  localparam int PSCR_SLOT_DEN_TOP = 6;
  localparam int PSCR_SLOT_DEN_MID = 7;
  localparam int PSCR_SLOT_DEN_LOW = 8;
  localparam int PSCR_SLOT_MOD_CTRL = 9;
  localparam int PSCR_SLOT_LF_R2 = 10;

  // ----------------------------------------------------------------
  // Reset values and writable-bit masks, per slot
  // ----------------------------------------------------------------
  localparam logic [7:0] PSCR_RST [PSCR_NUM_REGS] = '{
    8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h24};
  localparam logic [7:0] PSCR_MASK [PSCR_NUM_REGS] = '{
    8'h3F, 8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'h3F};

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int PSCR_DBL_BIT = 4;
  localparam int PSCR_CP_W = 4;
  localparam int PSCR_INT_HI_W = 4;
  localparam int PSCR_INT_DIV_W = 12;
  localparam int PSCR_FRAC_TOP_W = 6;
  localparam int PSCR_FRAC_W = 22;
  localparam int PSCR_ORDER_LSB = 0;
  localparam int PSCR_DITHER_LSB = 2;
  localparam int PSCR_R2_W = 6;
  localparam int PSCR_CUR_W = 14;

  // Pump current step per weight unit, in microamps
  localparam int PSCR_CP_STEP_UA = 400;
  // Weights of pump code bits in steps: 0.4, 0.8, 1.6 and 6.4 mA
  localparam logic [4:0] PSCR_CP_WEIGHT [PSCR_CP_W] = '{5'h01, 5'h02, 5'h04, 5'h10};
  // Smallest division ratio the feedback divider can realise
  localparam logic [11:0] PSCR_INT_DIV_MIN = 12'h001;

  // Status register bit positions
  localparam int PSCR_ST_RATIO_LSB = 0;
  localparam int PSCR_ST_FRAC_BIT = 12;
  localparam int PSCR_ST_DEN_ZERO_BIT = 13;
  localparam int PSCR_ST_DITHER_BIT = 14;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSCR_ORDER_INT = 2'b00,
    PSCR_ORDER_1ST = 2'b01,
    PSCR_ORDER_2ND = 2'b10,
    PSCR_ORDER_3RD = 2'b11
  } pscr_order_t;

  typedef enum logic [1:0] {
    PSCR_DITHER_WEAK = 2'b00,
    PSCR_DITHER_MEDIUM = 2'b01,
    PSCR_DITHER_STRONG = 2'b10,
    PSCR_DITHER_OFF = 2'b11
  } pscr_dither_t;

endpackage : pscr_pkg

// ===== pscr_synth_decode.sv
`timescale 1ns/100ps
module pscr_synth_decode (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw fields
  input wire logic [pscr_pkg::PSCR_CP_W-1:0] pump_current_code,
  input wire logic [pscr_pkg::PSCR_INT_DIV_W-1:0] feedback_int_divider,
  input wire logic [pscr_pkg::PSCR_FRAC_W-1:0] frac_numerator,
  input wire logic [pscr_pkg::PSCR_FRAC_W-1:0] frac_denominator,
  input wire pscr_pkg::pscr_order_t modulator_order,
  input wire pscr_pkg::pscr_dither_t modulator_dither_sel,
  // Decoded synthesizer controls
  output logic [pscr_pkg::PSCR_CUR_W-1:0] pump_current_ua,
  output logic [pscr_pkg::PSCR_INT_DIV_W-1:0] fb_int_ratio,
  output logic [pscr_pkg::PSCR_FRAC_W-1:0] fb_frac_num,
  output logic [pscr_pkg::PSCR_FRAC_W-1:0] fb_frac_den,
  output logic fb_frac_active,
  output logic fb_den_zero,
  output logic dither_active
);
  import pscr_pkg::*;

  logic [PSCR_CUR_W-1:0] cur_r, cur_nxt;
  logic [PSCR_INT_DIV_W-1:0] ratio_r, ratio_nxt;
  logic [PSCR_FRAC_W-1:0] num_r, num_nxt, den_r, den_nxt;
  logic frac_r, frac_nxt, dz_r, dz_nxt, dith_r, dith_nxt;
  logic [PSCR_CUR_W-1:0] cur_sum;

  // ----------------------------------------------------------------
  // Pump current: each set code bit adds its weight
  // ----------------------------------------------------------------
  always_comb begin
    cur_sum = '0;
    for (int i = 0; i < PSCR_CP_W; i++) begin
      if (pump_current_code[i]) begin
        cur_sum = cur_sum + PSCR_CUR_W'(PSCR_CP_WEIGHT[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Next values of the decoded controls
  // ----------------------------------------------------------------
  always_comb begin
    cur_nxt = PSCR_CUR_W'(cur_sum * PSCR_CUR_W'(PSCR_CP_STEP_UA));
    // Codes 0 and 1 both divide by one
    if (feedback_int_divider <= PSCR_INT_DIV_MIN) begin
      ratio_nxt = PSCR_INT_DIV_MIN;
    end else begin
      ratio_nxt = feedback_int_divider;
    end
    // A zero denominator would make the fraction meaningless, so fall back to integer
    dz_nxt = (frac_denominator == '0);
    frac_nxt = (modulator_order != PSCR_ORDER_INT) && !dz_nxt;
    if (frac_nxt) begin
      num_nxt = frac_numerator;
      den_nxt = frac_denominator;
    end else begin
      num_nxt = '0;
      den_nxt = '0;
    end
    // Dither only matters while the modulator runs
    dith_nxt = (modulator_dither_sel != PSCR_DITHER_OFF) && frac_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r <= '0;
      ratio_r <= PSCR_INT_DIV_MIN;
      num_r <= '0;
      den_r <= '0;
      frac_r <= 1'b0;
      dz_r <= 1'b0;
      dith_r <= 1'b0;
    end else begin
      cur_r <= cur_nxt;
      ratio_r <= ratio_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
      frac_r <= frac_nxt;
      dz_r <= dz_nxt;
      dith_r <= dith_nxt;
    end
  end

  assign pump_current_ua = cur_r;
  assign fb_int_ratio = ratio_r;
  assign fb_frac_num = num_r;
  assign fb_frac_den = den_r;
  assign fb_frac_active = frac_r;
  assign fb_den_zero = dz_r;
  assign dither_active = dith_r;

endmodule : pscr_synth_decode

// ===== pscr_regs_asserts.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port-level checker for the synthesizer register bank
// ------------------------------------------------------------
module pscr_regs_asserts (
  // Clock, reset and APB request
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pscr_pkg::PSCR_ADDR_W-1:0] paddr,
  input wire logic [pscr_pkg::PSCR_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  // Raw and decoded fields
  input wire logic primary_ref_doubler_en,
  input wire logic [pscr_pkg::PSCR_CP_W-1:0] pump_current_code,
  input wire logic [pscr_pkg::PSCR_INT_DIV_W-1:0] feedback_int_divider,
  input wire logic [pscr_pkg::PSCR_FRAC_W-1:0] frac_numerator,
  input wire logic [pscr_pkg::PSCR_FRAC_W-1:0] frac_denominator,
  input wire pscr_pkg::pscr_order_t modulator_order,
  input wire pscr_pkg::pscr_dither_t modulator_dither_sel,
  input wire logic [pscr_pkg::PSCR_R2_W-1:0] loop_filter_r2_code,
  input wire logic [pscr_pkg::PSCR_CUR_W-1:0] pump_current_ua,
  input wire logic [pscr_pkg::PSCR_INT_DIV_W-1:0] fb_int_ratio,
  input wire logic [pscr_pkg::PSCR_FRAC_W-1:0] fb_frac_num,
  input wire logic fb_frac_active,
  input wire logic dither_active,
  input wire logic config_update
);
  import pscr_pkg::*;
  logic wr_go;
  logic [13:0] ua_exp;
  // Landing write and pump current worked out from the code weights
  assign wr_go = psel && penable && pwrite && pstrb[0];
  assign ua_exp = 14'(400 * (pump_current_code[0] + 2 * pump_current_code[1] + 4 * pump_current_code[2]
                  + 16 * pump_current_code[3]));
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Checks start one edge after release; dither_on_a has no presetn antecedent, so its $past still sees a reset-time value
  rst_raw_a: assert property ($rose(presetn) |-> primary_ref_doubler_en && pump_current_code == 4'h8
    && feedback_int_divider == 12'h066 && loop_filter_r2_code == 6'h24) else $error("reset field values wrong");
  rst_frac_a: assert property ($rose(presetn) |-> frac_numerator == 22'h0 && frac_denominator == 22'h0
    && modulator_order == PSCR_ORDER_INT && modulator_dither_sel == PSCR_DITHER_OFF) else $error("reset mode wrong");
  // Sampled presetn gates the attempt, so the release edge itself never starts one
  pump_ua_a: assert property (presetn |=> pump_current_ua == $past(ua_exp)) else $error("pump current wrong");
  int_ratio_a: assert property (presetn |=> fb_int_ratio == ($past(feedback_int_divider) <= 12'h001 ?
    12'h001 : $past(feedback_int_divider))) else $error("divider ratio wrong");
  frac_on_a: assert property (presetn |=> fb_frac_active == ($past(modulator_order) != PSCR_ORDER_INT
    && $past(frac_denominator) != 22'h0)) else $error("fraction enable wrong");
  frac_gate_a: assert property (presetn |=> fb_frac_num == (fb_frac_active ? $past(frac_numerator) : 22'h0))
    else $error("fraction numerator gating wrong");
  dither_on_a: assert property (dither_active == (fb_frac_active
    && $past(modulator_dither_sel) != PSCR_DITHER_OFF)) else $error("dither enable wrong");
  r2_write_a: assert property (wr_go && paddr == 12'h10C |=> loop_filter_r2_code == $past(pwdata[5:0]))
    else $error("loop filter code not stored");
  div_high_a: assert property (wr_go && paddr == 12'hE8 |=> config_update
    && feedback_int_divider[11:8] == $past(pwdata[3:0])) else $error("divider high nibble not stored");
  den_hold_a: assert property (!(psel && penable && pwrite) |=> $stable(frac_denominator))
    else $error("denominator changed without write");
endmodule : pscr_regs_asserts

bind pscr_regs pscr_regs_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .primary_ref_doubler_en, .pump_current_code, .feedback_int_divider, .frac_numerator, .frac_denominator,
  .modulator_order, .modulator_dither_sel, .loop_filter_r2_code, .pump_current_ua, .fb_int_ratio,
  .fb_frac_num, .fb_frac_active, .dither_active, .config_update);

// ===== pscr_regs_tb.sv
`timescale 1ns/100ps
module pscr_regs_tb;
  import pscr_pkg::*;
  // ------------------------------------------------------------
  // Signals and expectation tables
  // ------------------------------------------------------------
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [3:0] pstrb = 4'h0, pump_current_code;
  logic pready, pslverr, primary_ref_doubler_en, fb_frac_active, dither_active, config_update, rerr;
  logic [11:0] feedback_int_divider, fb_int_ratio;
  logic [21:0] frac_numerator, frac_denominator, fb_frac_num, fb_frac_den;
  logic [13:0] pump_current_ua;
  logic [5:0] loop_filter_r2_code;
  pscr_order_t modulator_order;
  pscr_dither_t modulator_dither_sel;
  int fails = 0, cmp_count = 0;
  logic [7:0] rst_v [11] = '{8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h24};
  logic [3:0] cp_v [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h5, 4'h6, 4'h7};
  int cp_ua [8] = '{400, 800, 1600, 6400, 1200, 2000, 2400, 2800};
  logic [11:0] dv [4] = '{12'h000, 12'h001, 12'h002, 12'hFFF};
  int rt [4] = '{1, 1, 2, 4095};
  logic [7:0] r2v [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h30};

  pscr_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .primary_ref_doubler_en, .pump_current_code, .feedback_int_divider, .frac_numerator, .frac_denominator,
    .modulator_order, .modulator_dither_sel, .loop_filter_r2_code, .pump_current_ua, .fb_int_ratio,
    .fb_frac_num, .fb_frac_den, .fb_frac_active, .dither_active, .config_update);

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so no signal is driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] st);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      fails++;
      give_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 32'h0, 4'h0);
    chk($sformatf("reg %h", idx), {24'h0, exp}, rdat);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'h1, idx, {24'h0, d}, 4'hF);
  endtask : wr

  // Decoded outputs trail the raw fields by one cycle
  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask : settle

  // ------------------------------------------------------------
  // Clock and test sequence
  // ------------------------------------------------------------
  initial begin
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    // Decoded outputs load at the first edge after release, so look one edge later
    repeat (2) @(posedge pclk);
    chk("ratio", 32'h66, 32'(fb_int_ratio));
    chk("pump_ua", 32'h1900, 32'(pump_current_ua));
    for (int i = 0; i < 11; i++) rd(8'h39 + 8'(i), rst_v[i]);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h39, {4'h0, cp_v[i]});
      settle();
      chk("pump_ua", 32'(cp_ua[i]), 32'(pump_current_ua));
      chk("doubler", 32'h0, 32'(primary_ref_doubler_en));
    end
    wr(8'h39, 8'h18);
    chk("doubler", 32'h1, 32'(primary_ref_doubler_en));
    $display("test pump and doubler done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h3A, {4'hF, dv[i][11:8]});
      wr(8'h3B, dv[i][7:0]);
      settle();
      chk("int_div", 32'(dv[i]), 32'(feedback_int_divider));
      chk("ratio", 32'(rt[i]), 32'(fb_int_ratio));
    end
    rd(8'h3A, 8'h0F);
    $display("test divider done");
    wr(8'h3C, 8'hFF);
    wr(8'h3D, 8'hA5);
    wr(8'h3E, 8'h5A);
    wr(8'h3F, 8'h2A);
    wr(8'h40, 8'h01);
    wr(8'h41, 8'h80);
    chk("num", 32'h3FA55A, 32'(frac_numerator));
    chk("den", 32'h2A0180, 32'(frac_denominator));
    rd(8'h3C, 8'h3F);
    // Every order and dither code; the fraction counts only when the order is not integer
    for (int i = 0; i < 16; i++) begin
      wr(8'h42, 8'(i));
      settle();
      chk("order", 32'(i % 4), 32'(modulator_order));
      chk("dither", 32'(i / 4), 32'(modulator_dither_sel));
      chk("frac_on", 32'(i % 4 != 0), 32'(fb_frac_active));
      chk("dither_on", 32'(i % 4 != 0 && i / 4 != 3), 32'(dither_active));
      chk("frac_num", (i % 4 != 0) ? 32'h3FA55A : 32'h0, 32'(fb_frac_num));
      chk("frac_den", (i % 4 != 0) ? 32'h2A0180 : 32'h0, 32'(fb_frac_den));
    end
    wr(8'h3F, 8'h00);
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h00);
    settle();
    chk("frac_on", 32'h0, 32'(fb_frac_active));
    // Status word: ratio 4095, denominator zero, fraction and dither off
    apb(1'h0, 8'h44, 32'h0, 4'h0);
    chk("status", 32'h2FFF, rdat);
    apb(1'h1, 8'h44, 32'hFF, 4'hF);
    chk("status_wr_err", 32'h0, 32'(rerr));
    $display("test modulator done");
    for (int i = 0; i < 6; i++) begin
      wr(8'h43, r2v[i]);
      chk("r2", 32'(r2v[i]), 32'(loop_filter_r2_code));
    end
    wr(8'h43, 8'hFF);
    rd(8'h43, 8'h3F);
    $display("test loop filter done");
    // Unmapped read errors; a write without the low strobe leaves the register alone
    apb(1'h0, 8'h45, 32'h0, 4'h0);
    chk("pslverr", 32'h1, 32'(rerr));
    chk("prdata", 32'h0, rdat);
    apb(1'h1, 8'h43, 32'h11, 4'h0);
    rd(8'h43, 8'h3F);
    $display("test refusals done");
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(8'h43, 8'h24);
    rd(8'h39, 8'h18);
    $display("test second reset done");
    give_verdict();
  end
endmodule : pscr_regs_tb
